/* logic/tsmc_regs.svh */
// Constants of the task scheduler and mode control block
// Assumes inclusion by bare name from logic/
`ifndef TSMC_REGS_SVH
`define TSMC_REGS_SVH
// Priority range, lower value wins
`define TSMC_PRIO_MIN   3'h2
`define TSMC_PRIO_MAX   3'h7
// Reset and saturation values of runtime statistics
`define TSMC_BEST_INIT  16'hffff
`define TSMC_RT_ZERO    16'h0000
`define TSMC_RT_SAT     16'hffff
// Timing, in nanoseconds and milliseconds
`define TSMC_CLK_NS     50
`define TSMC_MS_NS      1000000
`define TSMC_OUTAGE_MS  8'h14
`define TSMC_OUT_SAT    8'hff
// Task id coding: device tasks start here
`define TSMC_DEV_BASE   1'b1
`endif

/* logic/tsmc_pkg.sv */
// Types of the task scheduler and mode control block
// Assumes nothing beyond a SystemVerilog compiler
package tsmc_pkg;
  typedef enum logic [2:0] {
    ST_STOP_CLR,
    ST_STOP_REF,
    ST_STOP,
    ST_RUN_INIT,
    ST_RUN,
    ST_DEBUG
  } tsmc_mode_e;
  typedef logic [5:0] tsmc_slot_t;
endpackage

/* logic/tsmc_core.sv */
// Task scheduler with operating mode control
// Assumes all inputs but power_fail_in are on core_clk_in
//
// What this block does
// - Each periodic task raises a request whenever its interval elapses
// - A periodic request for a running or pending task is dropped
// - Interval timers advance only in run mode with power present
// - Worst, best and last runtime kept for periodic slots 0 to 31
// - Best runtime resets to ffff so unused tasks stay visible
// - Device-condition tasks are sampled only when the scan ends
// - A condition gone before scan end never starts its task
// - After a long outage all pending requests are discarded
// - Outage up to 20 ms keeps pending tasks; duplicates dropped
// - On task end the highest priority pending task is dispatched
// - Lock holds requests pending until unlock; software issues both
// - A periodic task suspends the scan, which resumes afterwards
// - Higher periodic task preempts a device task, which later resumes
// - Three operating modes: run, stop and debug
// - Entering run initialises data, checks program, runs only if valid
// - Run mode refreshes I/O and dispatches detected tasks
// - Entering stop from run or debug, or on an invalid program, clears the output image then refreshes outputs
// - Stop runs no user program but refreshes I/O and services
// - Download accepted only in remotely commanded stop mode
// - Priority levels 2 to 7, lower value wins
// - Equal priority pending tasks are dispatched one after another
// - Periodic interval is given in 1 ms units
`timescale 1ns/1ps
`include "tsmc_regs.svh"
module tsmc_core #(
  parameter int NPER      = 32,
  parameter int NDEV      = 32,
  parameter int MS_CYCLES = (`TSMC_MS_NS + `TSMC_CLK_NS - 1) / `TSMC_CLK_NS
)(
  input  wire logic                core_clk_in,
  input  wire logic                resetn_in,
  input  wire logic [NPER*32-1:0]  per_interval_in,
  input  wire logic [NPER*3-1:0]   per_prio_in,
  input  wire logic [NDEV-1:0]     dev_enable_in,
  input  wire logic [NDEV-1:0]     dev_cond_in,
  input  wire logic [NDEV*3-1:0]   dev_prio_in,
  input  wire logic                scan_done_in,
  input  wire logic                task_done_in,
  input  wire logic                task_preempt_lock_in,
  input  wire logic                task_preempt_unlock_in,
  input  wire logic                power_fail_in,
  input  wire logic                run_req_in,
  input  wire logic                stop_req_in,
  input  wire logic                debug_req_in,
  input  wire logic                remote_mode_in,
  input  wire logic                program_valid_in,
  input  wire logic                download_req_in,
  output logic                     task_start_out,
  output logic                     task_resume_out,
  output logic [6:0]               task_id_out,
  output logic                     scan_hold_out,
  output logic                     preempt_locked_out,
  output logic [NPER*16-1:0]       periodic_task_worst_runtime_out,
  output logic [NPER*16-1:0]       periodic_task_best_runtime_out,
  output logic [NPER*16-1:0]       periodic_task_last_runtime_out,
  output logic                     run_mode_out,
  output logic                     stop_mode_out,
  output logic                     debug_mode_out,
  output logic                     data_init_out,
  output logic                     output_clear_out,
  output logic                     io_refresh_out,
  output logic                     service_out,
  output logic                     download_accept_out
);
  // Refuse sizes that the 64-slot id coding or the 16-bit ms divider cannot serve
  if (NPER < 1 || NPER > 32 || NDEV < 1 || NDEV > 32
      || MS_CYCLES < 2 || MS_CYCLES > 65536)
  begin : g_param_check
    $error("tsmc_core: unsupported parameter values");
  end

  // ------------------------------------------------------------
  // Arbitration function
  // ------------------------------------------------------------
  // Lowest priority value wins; ties go to the lowest slot, so
  // equal tasks are served one after another
  function automatic logic [9:0] pick_best(input logic [63:0] req,
                                           input logic [191:0] prio);
    logic [9:0] res;
    res = 10'h000;
    for (int i = 0; i < 64; i++)
    begin
      if (req[i] && (!res[9] || prio[i*3 +: 3] < res[8:6]))
        res = {1'b1, prio[i*3 +: 3], 6'(i)};
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  tsmc_pkg::tsmc_mode_e mode;
  tsmc_pkg::tsmc_mode_e next_mode;
  logic [31:0]          ivl_cnt [NPER];
  logic [15:0]          worst [NPER];
  logic [15:0]          best [NPER];
  logic [15:0]          last [NPER];
  logic [63:0]          pend;
  logic [15:0]          ms_div;
  logic                 ms_tick;
  logic                 pf_meta;
  logic                 pf_sync;
  logic                 pf_prev;
  logic [7:0]           outage_ms;
  logic                 locked;
  logic                 cur_valid;
  tsmc_pkg::tsmc_slot_t cur_idx;
  logic [2:0]           cur_prio;
  logic                 sav_valid;
  tsmc_pkg::tsmc_slot_t sav_idx;
  logic [2:0]           sav_prio;
  logic [15:0]          rt_cnt;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  wire          in_run     = (mode == tsmc_pkg::ST_RUN);
  wire          timing_ok  = in_run && !pf_sync;
  wire [191:0]  all_prio   = {{(32-NDEV)*3{1'b1}}, dev_prio_in,
                              {(32-NPER)*3{1'b1}}, per_prio_in};
  wire [63:0]   pend_ok    = locked ? 64'h0 : pend;
  wire [9:0]    best_pick  = pick_best(pend_ok, all_prio);
  wire          pick_v     = best_pick[9] && timing_ok;
  wire [2:0]    pick_prio  = best_pick[8:6];
  wire [5:0]    pick_idx   = best_pick[5:0];
  wire          pick_per   = !pick_idx[5];
  wire          done_now   = task_done_in && cur_valid;
  wire          preempt    = pick_v && pick_per && cur_valid && cur_idx[5]
                             && !sav_valid && !done_now
                             && pick_prio < cur_prio;
  wire          resume     = !cur_valid && sav_valid && timing_ok
                             && !(pick_v && pick_per && pick_prio < sav_prio);
  wire          start      = pick_v && (preempt || (!cur_valid && !resume));
  wire          long_out   = pf_prev && !pf_sync
                             && outage_ms > `TSMC_OUTAGE_MS;
  wire          clr_pend   = long_out || !in_run;
  wire [63:0]   busy_mask  = (cur_valid ? (64'h1 << cur_idx) : 64'h0)
                             | (sav_valid ? (64'h1 << sav_idx) : 64'h0)
                             | pend;

  // ------------------------------------------------------------
  // Time base and power sensing
  // ------------------------------------------------------------
  // Millisecond tick; power pin passes two flip-flops
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ms_div    <= 16'h0000;
      ms_tick   <= 1'b0;
      pf_meta   <= 1'b0;
      pf_sync   <= 1'b0;
      pf_prev   <= 1'b0;
      outage_ms <= 8'h00;
    end
    else
    begin
      ms_tick <= (ms_div == 16'(MS_CYCLES - 1));
      ms_div  <= (ms_div == 16'(MS_CYCLES - 1)) ? 16'h0000 : ms_div + 16'h0001;
      pf_meta <= power_fail_in;
      pf_sync <= pf_meta;
      pf_prev <= pf_sync;
      if (!pf_sync)
        outage_ms <= 8'h00;
      else if (ms_tick && outage_ms != `TSMC_OUT_SAT)
        outage_ms <= outage_ms + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Per-task interval timers and pending bits
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPER; g++)
    begin : g_per
      wire [31:0] ivl  = per_interval_in[g*32 +: 32];
      wire        fire = timing_ok && ms_tick && ivl != 32'h0
                         && ivl_cnt[g] <= 32'h1;
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          ivl_cnt[g] <= 32'h0;
        else if (mode == tsmc_pkg::ST_RUN_INIT || fire)
          ivl_cnt[g] <= ivl;
        else if (timing_ok && ms_tick)
          ivl_cnt[g] <= ivl_cnt[g] - 32'h1;
      end
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          pend[g] <= 1'b0;
        else if (fire && !busy_mask[g])
          pend[g] <= 1'b1;
        else if (clr_pend || (start && pick_idx == 6'(g)))
          pend[g] <= 1'b0;
      end
      assign periodic_task_worst_runtime_out[g*16 +: 16] = worst[g];
      assign periodic_task_best_runtime_out[g*16 +: 16]  = best[g];
      assign periodic_task_last_runtime_out[g*16 +: 16]  = last[g];
    end
    for (g = NPER; g < 32; g++)
    begin : g_per_off
      assign pend[g] = 1'b0;
    end
    for (g = 0; g < NDEV; g++)
    begin : g_dev
      // Sampled only at scan end
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          pend[32+g] <= 1'b0;
        else if (scan_done_in && in_run && dev_enable_in[g] && dev_cond_in[g]
                 && !busy_mask[32+g])
          pend[32+g] <= 1'b1;
        else if (clr_pend || (start && pick_idx == 6'(32 + g)))
          pend[32+g] <= 1'b0;
      end
    end
    for (g = 32 + NDEV; g < 64; g++)
    begin : g_dev_off
      assign pend[g] = 1'b0;
    end
  endgenerate

  // ------------------------------------------------------------
  // Dispatcher
  // ------------------------------------------------------------
  // One running task plus one preempted device task
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      locked          <= 1'b0;
      cur_valid       <= 1'b0;
      cur_idx         <= 6'h00;
      cur_prio        <= 3'h0;
      sav_valid       <= 1'b0;
      sav_idx         <= 6'h00;
      sav_prio        <= 3'h0;
      task_start_out  <= 1'b0;
      task_resume_out <= 1'b0;
      task_id_out     <= 7'h00;
    end
    else
    begin
      if (task_preempt_lock_in)
        locked <= 1'b1;
      else if (task_preempt_unlock_in)
        locked <= 1'b0;
      task_start_out  <= start;
      task_resume_out <= resume && !start;
      if (!in_run)
      begin
        cur_valid <= 1'b0;
        sav_valid <= 1'b0;
      end
      else if (start)
      begin
        if (preempt)
        begin
          sav_valid <= 1'b1;
          sav_idx   <= cur_idx;
          sav_prio  <= cur_prio;
        end
        cur_valid   <= 1'b1;
        cur_idx     <= pick_idx;
        cur_prio    <= pick_prio;
        task_id_out <= {pick_idx[5], 1'b0, pick_idx[4:0]};
      end
      else if (resume)
      begin
        sav_valid   <= 1'b0;
        cur_valid   <= 1'b1;
        cur_idx     <= sav_idx;
        cur_prio    <= sav_prio;
        task_id_out <= {`TSMC_DEV_BASE, 1'b0, sav_idx[4:0]};
      end
      else if (done_now)
        cur_valid <= 1'b0;
    end
  end

  assign scan_hold_out      = cur_valid || sav_valid;
  assign preempt_locked_out = locked;

  // ------------------------------------------------------------
  // Runtime statistics
  // ------------------------------------------------------------
  // Millisecond runtime of the running periodic task, saturating
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rt_cnt <= `TSMC_RT_ZERO;
    else if (start)
      rt_cnt <= `TSMC_RT_ZERO;
    else if (ms_tick && cur_valid && rt_cnt != `TSMC_RT_SAT)
      rt_cnt <= rt_cnt + 16'h0001;
  end

  generate
    for (g = 0; g < NPER; g++)
    begin : g_stat
      wire upd = done_now && cur_idx == 6'(g);
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          worst[g] <= `TSMC_RT_ZERO;
          best[g]  <= `TSMC_BEST_INIT;
          last[g]  <= `TSMC_RT_ZERO;
        end
        else if (upd)
        begin
          last[g] <= rt_cnt;
          if (rt_cnt > worst[g])
            worst[g] <= rt_cnt;
          if (rt_cnt < best[g])
            best[g] <= rt_cnt;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Operating mode control
  // ------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    case (mode)
      tsmc_pkg::ST_STOP_CLR: next_mode = tsmc_pkg::ST_STOP_REF;
      tsmc_pkg::ST_STOP_REF: next_mode = tsmc_pkg::ST_STOP;
      tsmc_pkg::ST_STOP:
        if (run_req_in)
          next_mode = tsmc_pkg::ST_RUN_INIT;
        else if (debug_req_in)
          next_mode = tsmc_pkg::ST_DEBUG;
      tsmc_pkg::ST_RUN_INIT:
        next_mode = program_valid_in ? tsmc_pkg::ST_RUN
                                     : tsmc_pkg::ST_STOP_CLR;
      tsmc_pkg::ST_RUN, tsmc_pkg::ST_DEBUG:
        if (stop_req_in)
          next_mode = tsmc_pkg::ST_STOP_CLR;
      default: next_mode = tsmc_pkg::ST_STOP_CLR;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mode                <= tsmc_pkg::ST_STOP_CLR;
      data_init_out       <= 1'b0;
      output_clear_out    <= 1'b0;
      io_refresh_out      <= 1'b0;
      service_out         <= 1'b0;
      download_accept_out <= 1'b0;
    end
    else
    begin
      mode             <= next_mode;
      data_init_out    <= (next_mode == tsmc_pkg::ST_RUN_INIT);
      output_clear_out <= (next_mode == tsmc_pkg::ST_STOP_CLR);
      io_refresh_out   <= ms_tick
                          || next_mode == tsmc_pkg::ST_STOP_REF;
      service_out      <= ms_tick;
      download_accept_out <= download_req_in && remote_mode_in
                             && mode == tsmc_pkg::ST_STOP;
    end
  end

  assign run_mode_out   = in_run;
  assign stop_mode_out  = (mode == tsmc_pkg::ST_STOP);
  assign debug_mode_out = (mode == tsmc_pkg::ST_DEBUG);

endmodule

/* verif/tsmc_core_asserts.sv */
// Port-level checker for the task scheduler and mode control block
// Assumes it is bound onto tsmc_core and sees only its ports
`timescale 1ns/1ps
module tsmc_core_asserts #(
  parameter int NPER      = 32,
  parameter int NDEV      = 32,
  parameter int MS_CYCLES = 20000
)(
  input wire logic               core_clk_in,
  input wire logic               resetn_in,
  input wire logic               run_req_in,
  input wire logic               stop_req_in,
  input wire logic               program_valid_in,
  input wire logic               download_req_in,
  input wire logic               remote_mode_in,
  input wire logic               task_done_in,
  input wire logic               task_start_out,
  input wire logic               task_resume_out,
  input wire logic [6:0]         task_id_out,
  input wire logic               scan_hold_out,
  input wire logic               preempt_locked_out,
  input wire logic [NPER*16-1:0] periodic_task_last_runtime_out,
  input wire logic               run_mode_out,
  input wire logic               stop_mode_out,
  input wire logic               debug_mode_out,
  input wire logic               data_init_out,
  input wire logic               output_clear_out,
  input wire logic               io_refresh_out,
  input wire logic               download_accept_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------
  // Mode sequencing
  // ----------------------------------------
  a_run_entry_init: assert property (stop_mode_out && run_req_in |=> data_init_out)
    else $error("run request in stop gave no data init");
  a_run_valid_go: assert property (data_init_out && program_valid_in |=> run_mode_out)
    else $error("valid program did not enter run");
  a_run_invalid_back: assert property (data_init_out && !program_valid_in
    |=> output_clear_out && !run_mode_out)
    else $error("invalid program entered run");
  a_stop_entry_seq: assert property (run_mode_out && stop_req_in
    |=> output_clear_out ##1 io_refresh_out ##1 stop_mode_out)
    else $error("stop entry sequence wrong");
  a_stop_no_task: assert property (stop_mode_out |-> !task_start_out && !scan_hold_out)
    else $error("task active in stop");
  a_mode_single: assert property ($onehot0({run_mode_out, stop_mode_out, debug_mode_out}))
    else $error("more than one mode active");
  a_download_gate: assert property (download_accept_out
    == $past(download_req_in && remote_mode_in && stop_mode_out))
    else $error("download accept mismatch");
  // ----------------------------------------
  // Dispatch and statistics
  // ----------------------------------------
  a_lock_no_start: assert property ($past(preempt_locked_out) && preempt_locked_out
    |-> !task_start_out)
    else $error("task started while locked");
  a_start_holds_scan: assert property (task_start_out |-> scan_hold_out)
    else $error("scan not suspended by task");
  a_start_in_run: assert property (task_start_out |-> $past(run_mode_out))
    else $error("task started outside run");
  a_stats_on_done: assert property ($changed(periodic_task_last_runtime_out)
    |-> $past(task_done_in))
    else $error("runtime changed without task end");
  // Main scenarios seen
  c_device_start: cover property (task_start_out && task_id_out[6]);
  c_resume: cover property (task_resume_out);
  c_download: cover property (download_accept_out);
endmodule
bind tsmc_core tsmc_core_asserts #(.NPER(NPER), .NDEV(NDEV), .MS_CYCLES(MS_CYCLES)) chk_u (.*);

/* verif/tsmc_core_bench.sv */
// Self-checking bench for the task scheduler and mode control block
// Assumes logic/ on the include path; counts shortened by parameters
`timescale 1ns/1ps
`include "tsmc_regs.svh"
module tsmc_core_bench;
  localparam int NP = 4;
  localparam int ND = 4;
  localparam int MC = 4;
  localparam logic [7:0] P_SCAN = 8'h01, P_DONE = 8'h02, P_LOCK = 8'h04, P_UNLK = 8'h08;
  localparam logic [7:0] P_RUN = 8'h10, P_STOP = 8'h20, P_DBG = 8'h40, P_DL = 8'h80;
  logic             core_clk_in, resetn_in, power_fail_in, remote_mode_in, program_valid_in;
  logic [NP*32-1:0] per_interval_in;
  logic [NP*3-1:0]  per_prio_in;
  logic [ND-1:0]    dev_enable_in, dev_cond_in;
  logic [ND*3-1:0]  dev_prio_in;
  logic [7:0]       pv;
  wire logic        scan_done_in, task_done_in, task_preempt_lock_in, task_preempt_unlock_in;
  wire logic        run_req_in, stop_req_in, debug_req_in, download_req_in;
  logic             task_start_out, task_resume_out, scan_hold_out, preempt_locked_out;
  logic [6:0]       task_id_out;
  logic [NP*16-1:0] periodic_task_worst_runtime_out, periodic_task_best_runtime_out;
  logic [NP*16-1:0] periodic_task_last_runtime_out;
  logic             run_mode_out, stop_mode_out, debug_mode_out, data_init_out;
  logic             output_clear_out, io_refresh_out, service_out, download_accept_out;
  int               errors, checked, cyc, t0, k;
  // Pulse inputs come from one vector so a task can raise any of them
  assign {download_req_in, debug_req_in, stop_req_in, run_req_in, task_preempt_unlock_in,
          task_preempt_lock_in, task_done_in, scan_done_in} = pv;
  tsmc_core #(.NPER(NP), .NDEV(ND), .MS_CYCLES(MC)) dut_u (.*);
  // Clock, 50 ns period
  initial
  begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  // Cycle count and hang limit
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      results();
    end
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic pulse(input logic [7:0] v);
    pv <= v;
    tick(1);
    pv <= 8'h00;
    tick(1);
  endtask
  task automatic wait_start(input logic [6:0] exp);
    int n;
    n = 0;
    tick(1);
    while (task_start_out !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    check({task_start_out, 8'h00, task_id_out}, {1'b1, 8'h00, exp});
  endtask
  task automatic no_start(input int n);
    int c;
    c = 0;
    repeat (n)
    begin
      tick(1);
      if (task_start_out === 1'b1) c++;
    end
    check(c[15:0], 16'h0000);
  endtask
  task automatic results;
    $display("Comparisons %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    errors = 0; checked = 0; cyc = 0; pv = 8'h00; resetn_in = 1'b0;
    power_fail_in = 1'b0; remote_mode_in = 1'b0; program_valid_in = 1'b0;
    per_interval_in = '0; per_prio_in = '0; dev_enable_in = '0; dev_cond_in = '0;
    dev_prio_in = '0;
    tick(6);
    resetn_in <= 1'b1;
    tick(4);
    for (int g = 0; g < NP; g++)
    begin
      check(periodic_task_best_runtime_out[g*16+:16], `TSMC_BEST_INIT);
      check(periodic_task_worst_runtime_out[g*16+:16], `TSMC_RT_ZERO);
    end
    check({15'h0, stop_mode_out}, 16'h1);
    // Stop keeps refreshing I/O and servicing once per ms
    k = 0;
    repeat (4 * MC)
    begin
      tick(1);
      k = k + int'(service_out) + int'(io_refresh_out);
    end
    check(16'(k), 16'h8);
    // Invalid program falls back to stop
    pulse(P_RUN);
    check({15'h0, data_init_out}, 16'h1);
    tick(4);
    check({14'h0, run_mode_out, stop_mode_out}, 16'h1);
    // Download only in remotely commanded stop
    remote_mode_in <= 1'b1;
    pulse(P_DL);
    check({15'h0, download_accept_out}, 16'h1);
    remote_mode_in <= 1'b0;
    pulse(P_DL);
    check({15'h0, download_accept_out}, 16'h0);
    pulse(P_DBG);
    tick(2);
    check({15'h0, debug_mode_out}, 16'h1);
    pulse(P_STOP);
    tick(4);
    // Periodic slot 0 every 2 ms, device 1 urgent, others low
    per_interval_in[31:0] <= 32'h2;
    per_prio_in[2:0] <= 3'h3;
    dev_prio_in <= {3'h5, 3'h5, 3'h2, 3'h5};
    dev_enable_in <= 4'h7;
    program_valid_in <= 1'b1;
    pulse(P_RUN);
    tick(1);
    check({15'h0, run_mode_out}, 16'h1);
    wait_start(7'h00);
    t0 = cyc;
    pulse(P_DONE);
    wait_start(7'h00);
    check(16'(cyc - t0), 16'(2 * MC));
    check({15'h0, scan_hold_out}, 16'h1);
    tick(24);
    pulse(P_DONE);
    no_start(4);
    k = int'(periodic_task_last_runtime_out[15:0]);
    check({15'h0, k == 6 || k == 7}, 16'h1);
    check(periodic_task_worst_runtime_out[15:0], periodic_task_last_runtime_out[15:0]);
    check({15'h0, periodic_task_best_runtime_out[15:0] <= 16'h1}, 16'h1);
    // Device task preempted by the periodic task, then resumed
    wait_start(7'h00);
    pulse(P_DONE);
    dev_cond_in <= 4'h1;
    pulse(P_SCAN);
    wait_start(7'h40);
    wait_start(7'h00);
    pulse(P_DONE);
    k = 0;
    while (task_resume_out !== 1'b1 && k < 10)
    begin
      tick(1);
      k++;
    end
    check({15'h0, task_resume_out}, 16'h1);
    pulse(P_DONE);
    dev_cond_in <= 4'h0;
    pulse(P_STOP);
    tick(3);
    check({15'h0, stop_mode_out}, 16'h1);
    // Device tasks only: sampling, lock and priority order
    per_interval_in <= '0;
    pulse(P_RUN);
    dev_cond_in <= 4'h1;
    tick(2);
    dev_cond_in <= 4'h0;
    pulse(P_SCAN);
    no_start(5);
    pulse(P_LOCK);
    check({15'h0, preempt_locked_out}, 16'h1);
    dev_cond_in <= 4'hf;
    pulse(P_SCAN);
    dev_cond_in <= 4'h0;
    no_start(6);
    pulse(P_UNLK);
    wait_start(7'h41);
    pulse(P_DONE);
    wait_start(7'h40);
    pulse(P_DONE);
    wait_start(7'h42);
    pulse(P_DONE);
    no_start(4);
    // Short then long outage with a task pending
    for (int r = 0; r < 2; r++)
    begin
      pulse(P_LOCK);
      dev_cond_in <= 4'h1;
      pulse(P_SCAN);
      dev_cond_in <= 4'h0;
      power_fail_in <= 1'b1;
      tick(r == 0 ? 2 * MC : 25 * MC + 20);
      power_fail_in <= 1'b0;
      tick(4);
      pulse(P_UNLK);
      if (r == 0)
      begin
        wait_start(7'h40);
        pulse(P_DONE);
      end
      else
        no_start(6);
    end
    results();
  end
endmodule
